// >>> rtl/configurable_io_port_pins.sv
// How it works
// - Each pin selects one of four output types.
// - Two config registers per port pick type.
// - Reset-shared pin is always input-only.
// - Serial clock and data pins: input or open-drain.
// - Open-drain: no pull-ups, pull-down on zero.
// - Push-pull drives latch one strongly high.
// - Input-only turns every driver off.
// - Quasi: weak high, strong low.
// - Quasi pins read input without reconfiguring.
// - Inputs pass a glitch suppression filter.
// - Port 0 pins 1-5 have input disables.
// - Reset clears all five input disable bits.
// - After reset every pin is input-only.
// - Ports 0-2 have eight pins, port 3 two.
// - Available pins depend on clock and reset option.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
module configurable_io_port_pins (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           nrst,
    // AXI4-Lite write address
    input  wire logic                           awvalid,
    output logic                                awready,
    input  wire logic [gpio_cfg_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                     awprot,
    // AXI4-Lite write data
    input  wire logic                           wvalid,
    output logic                                wready,
    input  wire logic [gpio_cfg_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]                     wstrb,
    // AXI4-Lite write response
    output logic                                bvalid,
    input  wire logic                           bready,
    output logic [1:0]                          bresp,
    // AXI4-Lite read address
    input  wire logic                           arvalid,
    output logic                                arready,
    input  wire logic [gpio_cfg_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                     arprot,
    // AXI4-Lite read data
    output logic                                rvalid,
    input  wire logic                           rready,
    output logic [gpio_cfg_pkg::DATA_W-1:0]     rdata,
    output logic [1:0]                          rresp,
    // Pins
    input  wire logic [gpio_cfg_pkg::NUM_PINS-1:0] pinIn,
    output logic [gpio_cfg_pkg::NUM_PINS-1:0]      pinOut,
    output logic [gpio_cfg_pkg::NUM_PINS-1:0]      pinOe,
    output logic [gpio_cfg_pkg::NUM_PINS-1:0]      pinWeakPullup,
    // Digital inputs to peripherals
    output logic [gpio_cfg_pkg::NUM_PINS-1:0]      pinDigital
);
    import gpio_cfg_pkg::*;

    logic [7:0]          latchReg [NUM_PORTS];
    logic [7:0]          cfg1Reg  [NUM_PORTS];
    logic [7:0]          cfg2Reg  [NUM_PORTS];
    logic [7:0]          adisReg;
    logic [2:0]          optionReg;
    logic                awHeld;
    logic                wHeld;
    logic [5:0]          awIdx;
    logic [7:0]          wByte;
    logic                wLane0;
    logic                doWrite;
    logic                wrHit;
    logic [DATA_W-1:0]   rdNext;
    logic                rdHit;
    logic [NUM_PINS-1:0] latchFlat;
    logic [NUM_PINS-1:0] availMask;
    logic [NUM_PINS-1:0] filtFlat;
    logic [NUM_PINS-1:0] readFlat;
    logic [4:0]          ioCount;
    logic [1:0]          clkSel;
    logic                rpe;
    pin_type_t           typeFlat [NUM_PINS];

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    assign awready = !awHeld && !bvalid;
    assign wready  = !wHeld && !bvalid;
    assign doWrite = awHeld && wHeld && !bvalid;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            awHeld <= 1'b0;
            awIdx  <= '0;
        end else if (awvalid && awready) begin
            awHeld <= 1'b1;
            awIdx  <= awaddr[7:2];
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wHeld  <= 1'b0;
            wByte  <= '0;
            wLane0 <= 1'b0;
        end else if (wvalid && wready) begin
            wHeld  <= 1'b1;
            wByte  <= wdata[7:0];
            wLane0 <= wstrb[0];
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    assign wrHit = (awIdx <= IDX_OPTION) && (awIdx < IDX_PINS0 ||
                                             awIdx >= IDX_ADIS);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    function automatic logic [7:0] port_mask(input int p);
        return (p == NUM_PORTS - 1) ? PORT3_MASK : FULL_MASK;
    endfunction

    function automatic logic [7:0] cfg1_set(input int p);
        return (p == 1) ? P1_CFG1_SET : 8'h00;
    endfunction

    function automatic logic [7:0] cfg2_clr(input int p);
        return (p == 1) ? P1_CFG2_CLR : 8'h00;
    endfunction

    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    latchReg[p] <= LATCH_RST & port_mask(p);
                    cfg1Reg[p]  <= CFG1_RST & port_mask(p);
                    cfg2Reg[p]  <= CFG2_RST;
                end else if (doWrite && wLane0) begin
                    if (awIdx == IDX_LATCH0 + 6'(p)) begin
                        latchReg[p] <= wByte & port_mask(p);
                    end
                    if (awIdx == IDX_CFG1_0 + 6'(p)) begin
                        cfg1Reg[p] <= (wByte | cfg1_set(p)) &
                                      port_mask(p);
                    end
                    if (awIdx == IDX_CFG2_0 + 6'(p)) begin
                        cfg2Reg[p] <= wByte & ~cfg2_clr(p) &
                                      port_mask(p);
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!nrst) begin
            adisReg   <= ADIS_RST;
            optionReg <= OPTION_RST;
        end else if (doWrite && wLane0) begin
            if (awIdx == IDX_ADIS) begin
                adisReg <= wByte & ADIS_MASK;
            end
            if (awIdx == IDX_OPTION) begin
                optionReg <= wByte[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin availability by clock source and reset option
    // ------------------------------------------------------------
    assign clkSel = optionReg[OPT_CLK_LSB +: 2];
    assign rpe    = optionReg[OPT_RPE_BIT];

    always_comb begin
        availMask            = '1;
        availMask[PIN_RST]   = !rpe;
        availMask[PIN_XTAL1] = (clkSel == CLK_INTERNAL);
        availMask[PIN_XTAL2] = (clkSel != CLK_CRYSTAL);
    end

    assign ioCount = 5'(NUM_PINS) - 5'(rpe) -
                     5'(clkSel != CLK_INTERNAL) -
                     5'(clkSel == CLK_CRYSTAL);

    // ------------------------------------------------------------
    // Per-pin cells
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
            assign latchFlat[i] = latchReg[i / 8][i % 8];
            assign typeFlat[i]  = pin_type_t'({cfg1Reg[i / 8][i % 8],
                                              cfg2Reg[i / 8][i % 8]});

            pin_driver u_drv (
                .clk       (clk),
                .nrst      (nrst),
                .latchBit  (latchFlat[i]),
                .pinType   (typeFlat[i]),
                .available (availMask[i]),
                .drvOut    (pinOut[i]),
                .drvOe     (pinOe[i]),
                .weakPu    (pinWeakPullup[i])
            );

            pin_input_filter u_filt (
                .clk     (clk),
                .nrst    (nrst),
                .rawIn   (pinIn[i]),
                .filtOut (filtFlat[i])
            );

            if (i < PORT_W) begin : g_adis
                assign readFlat[i] = filtFlat[i] && availMask[i] &&
                                     !adisReg[i];
            end else begin : g_plain
                assign readFlat[i] = filtFlat[i] && availMask[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pinDigital <= '0;
        end else begin
            pinDigital <= readFlat;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    assign arready = !rvalid;

    always_comb begin
        logic [5:0] idx;
        logic [1:0] p;
        idx    = araddr[7:2];
        p      = idx[1:0];
        rdNext = '0;
        rdHit  = 1'b1;
        case (idx[5:2])
            4'h0: rdNext[7:0] = latchReg[p];
            4'h1: rdNext[7:0] = cfg1Reg[p];
            4'h2: rdNext[7:0] = cfg2Reg[p];
            4'h3: begin
                if (p == 2'h3) begin
                    rdNext[1:0] = readFlat[25:24];
                end else begin
                    rdNext[7:0] = readFlat[8 * p +: 8];
                end
            end
            4'h4: begin
                if (idx == IDX_ADIS) begin
                    rdNext[7:0] = adisReg;
                end else if (idx == IDX_OPTION) begin
                    rdNext[2:0] = optionReg;
                end else if (idx == IDX_STATUS) begin
                    rdNext[4:0] = ioCount;
                end else begin
                    rdHit = 1'b0;
                end
            end
            default: rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rdNext;
            rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reset_pin_off: assert property (
        @(posedge clk) disable iff (!nrst)
        !pinOe[PIN_RST] && !pinWeakPullup[PIN_RST])
        else $error("reset-shared pin is driven");

    a_serial_pins_od: assert property (
        @(posedge clk) disable iff (!nrst)
        !pinWeakPullup[PIN_SCL] && !pinWeakPullup[PIN_SDA] &&
        !pinOut[PIN_SCL] && !pinOut[PIN_SDA])
        else $error("serial pin drives high");

    a_adis_cleared: assert property (
        @(posedge clk)
        !nrst |=> adisReg == 8'h00)
        else $error("input disables not cleared by reset");

    a_adis_gates: assert property (
        @(posedge clk) disable iff (!nrst)
        adisReg[1] && $past(adisReg[1]) |-> !pinDigital[1])
        else $error("disabled port 0 input reaches logic");

    a_powerup_input: assert property (
        @(posedge clk)
        $past(!nrst) |-> pinOe == '0 && pinWeakPullup == '0)
        else $error("pin driven right after reset");

    a_write_answer: assert property (
        @(posedge clk) disable iff (!nrst)
        doWrite |=> bvalid)
        else $error("write response missing");

    a_read_answer: assert property (
        @(posedge clk) disable iff (!nrst)
        arvalid && arready |=> rvalid)
        else $error("read data missing");

    a_io_count: assert property (
        @(posedge clk) disable iff (!nrst)
        clkSel == CLK_CRYSTAL && rpe |-> ioCount == 5'h17)
        else $error("pin count wrong for crystal with reset pin");

endmodule

// >>> rtl/gpio_cfg_pkg.sv
package gpio_cfg_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PINS  = 26;
    localparam int NUM_PORTS = 4;
    localparam int PORT_W    = 8;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // ------------------------------------------------------------
    // Pin types, encoded by {cfg1 bit, cfg2 bit}
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PIN_QUASI     = 2'h0,
        PIN_PUSHPULL  = 2'h1,
        PIN_OPENDRAIN = 2'h3,
        PIN_INPUT     = 2'h2
    } pin_type_t;

    // ------------------------------------------------------------
    // Register word offsets (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_LATCH0 = 6'h00;
    localparam logic [5:0] IDX_CFG1_0 = 6'h04;
    localparam logic [5:0] IDX_CFG2_0 = 6'h08;
    localparam logic [5:0] IDX_PINS0  = 6'h0C;
    localparam logic [5:0] IDX_ADIS   = 6'h10;
    localparam logic [5:0] IDX_OPTION = 6'h11;
    localparam logic [5:0] IDX_STATUS = 6'h12;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] LATCH_RST   = 8'hFF;
    localparam logic [7:0] CFG1_RST    = 8'hFF;
    localparam logic [7:0] CFG2_RST    = 8'h00;
    localparam logic [7:0] ADIS_RST    = 8'h00;
    localparam logic [7:0] ADIS_MASK   = 8'h3E;
    localparam logic [7:0] PORT3_MASK  = 8'h03;
    localparam logic [7:0] FULL_MASK   = 8'hFF;
    localparam logic [7:0] P1_CFG1_SET = 8'h2C;
    localparam logic [7:0] P1_CFG2_CLR = 8'h20;
    localparam logic [2:0] OPTION_RST  = 3'h0;

    // ------------------------------------------------------------
    // Special pins, flat index = 8 * port + bit
    // ------------------------------------------------------------
    localparam int PIN_SCL   = 10;
    localparam int PIN_SDA   = 11;
    localparam int PIN_RST   = 13;
    localparam int PIN_XTAL2 = 24;
    localparam int PIN_XTAL1 = 25;

    // ------------------------------------------------------------
    // Clock source selection and option fields
    // ------------------------------------------------------------
    localparam logic [1:0] CLK_INTERNAL = 2'h0;
    localparam logic [1:0] CLK_EXTERNAL = 2'h1;
    localparam logic [1:0] CLK_CRYSTAL  = 2'h2;
    localparam int OPT_CLK_LSB = 0;
    localparam int OPT_RPE_BIT = 2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int GLITCH_NS     = 24;
    localparam int GLITCH_CYCLES =
        (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH_CNT_W  = 3;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> rtl/pin_driver.sv
module pin_driver (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    nrst,
    // Control
    input  wire logic                    latchBit,
    input  wire gpio_cfg_pkg::pin_type_t pinType,
    input  wire logic                    available,
    // Pin drive
    output logic                         drvOut,
    output logic                         drvOe,
    output logic                         weakPu
);
    import gpio_cfg_pkg::*;

    // ------------------------------------------------------------
    // Output stage per pin type
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            drvOut <= 1'b0;
            drvOe  <= 1'b0;
            weakPu <= 1'b0;
        end else if (!available) begin
            drvOut <= 1'b0;
            drvOe  <= 1'b0;
            weakPu <= 1'b0;
        end else begin
            case (pinType)
                PIN_QUASI: begin
                    drvOut <= 1'b0;
                    drvOe  <= !latchBit;
                    weakPu <= latchBit;
                end
                PIN_PUSHPULL: begin
                    drvOut <= latchBit;
                    drvOe  <= 1'b1;
                    weakPu <= 1'b0;
                end
                PIN_OPENDRAIN: begin
                    drvOut <= 1'b0;
                    drvOe  <= !latchBit;
                    weakPu <= 1'b0;
                end
                default: begin
                    drvOut <= 1'b0;
                    drvOe  <= 1'b0;
                    weakPu <= 1'b0;
                end
            endcase
        end
    end

    a_pushpull_drive: assert property (
        @(posedge clk) disable iff (!nrst)
        available && pinType == PIN_PUSHPULL |=>
            drvOe && drvOut == $past(latchBit))
        else $error("push-pull pin not driven from latch");

    a_opendrain_drive: assert property (
        @(posedge clk) disable iff (!nrst)
        available && pinType == PIN_OPENDRAIN |=>
            !weakPu && !drvOut && drvOe == !$past(latchBit))
        else $error("open-drain pin drive wrong");

    a_input_hiz: assert property (
        @(posedge clk) disable iff (!nrst)
        pinType == PIN_INPUT || !available |=> !drvOe && !weakPu)
        else $error("input-only pin is driven");

    a_quasi_weak: assert property (
        @(posedge clk) disable iff (!nrst)
        available && pinType == PIN_QUASI |=>
            (weakPu != drvOe) && weakPu == $past(latchBit))
        else $error("quasi pin drive wrong");

endmodule

// >>> rtl/pin_input_filter.sv
module pin_input_filter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Pin side
    input  wire logic rawIn,
    // Core side
    output logic      filtOut
);
    import gpio_cfg_pkg::*;

    logic                    syncQ1;
    logic                    syncQ2;
    logic [GLITCH_CNT_W-1:0] stableCnt;

    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            syncQ1 <= 1'b0;
            syncQ2 <= 1'b0;
        end else begin
            syncQ1 <= rawIn;
            syncQ2 <= syncQ1;
        end
    end

    // ------------------------------------------------------------
    // Glitch suppression: new level must hold GLITCH_CYCLES
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stableCnt <= '0;
            filtOut   <= 1'b0;
        end else if (syncQ2 == filtOut) begin
            stableCnt <= '0;
        end else if (stableCnt == GLITCH_CNT_W'(GLITCH_CYCLES - 1)) begin
            stableCnt <= '0;
            filtOut   <= syncQ2;
        end else begin
            stableCnt <= stableCnt + 1'b1;
        end
    end

    a_filter_no_glitch: assert property (
        @(posedge clk) disable iff (!nrst)
        $changed(filtOut) |->
            $past(syncQ2, 1) == filtOut &&
            $past(syncQ2, 2) == filtOut &&
            $past(syncQ2, 3) == filtOut)
        else $error("filtered input changed after a short pulse");

    a_filter_follows: assert property (
        @(posedge clk) disable iff (!nrst)
        (syncQ2 != filtOut) [*4] |-> $changed(filtOut))
        else $error("filtered input did not follow a steady level");

endmodule

// >>> tb/configurable_io_port_pins_tb.sv
module configurable_io_port_pins_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_cfg_pkg::*;
    // --------
    // Signals
    // --------
    logic          clk, nrst, awvalid, awready, wvalid, wready, bvalid;
    logic          bready, arvalid, arready, rvalid, rready;
    logic [7:0]    awaddr, araddr;
    logic [31:0]   wdata, rdata, rdat;
    logic [1:0]    bresp, rresp, resp;
    logic [25:0]   pinIn, pinOut, pinOe, pinWeakPullup, pinDigital;
    logic [25:0]   extLevel, extEn;
    int            failures, n_compared;
    configurable_io_port_pins dut_u (.clk, .nrst, .awvalid, .awready,
        .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF),
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .pinIn, .pinOut,
        .pinOe, .pinWeakPullup, .pinDigital);
    pin_world ext_u (.clk, .pinOut, .pinOe, .pinWeakPullup, .extLevel,
        .extEn, .pinIn);
    // --------
    // Tasks
    // --------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] ad(input logic [5:0] i, input int p);
        return {i + 6'(p), 2'b00};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic at, wt, bt;
        @(posedge clk);
        awaddr <= a;
        wdata <= 32'(d);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            at = awvalid && awready;
            wt = wvalid && wready;
            bt = bvalid;
            resp = bresp;
            @(posedge clk);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
        end while (!bt);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic at, rt;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            at = arvalid && arready;
            rt = rvalid;
            rdat = rdata;
            resp = rresp;
            @(posedge clk);
            if (at) arvalid <= 1'b0;
        end while (!rt);
        rready <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // --------
    // Tests
    // --------
    task automatic t_reset;
        chk(32'(pinOe | pinWeakPullup), 32'h0);
        rd(ad(IDX_CFG1_0, 0));
        chk(rdat, 32'(CFG1_RST));
        rd(ad(IDX_LATCH0, 3));
        chk(rdat, 32'h3);
        $display("t_reset done");
    endtask
    task automatic t_drive;
        wr(ad(IDX_CFG1_0, 0), 8'h00);
        wr(ad(IDX_CFG2_0, 0), 8'hFF);
        wr(ad(IDX_LATCH0, 0), 8'hA5);
        wr(ad(IDX_CFG1_0, 2), 8'h00);
        wr(ad(IDX_LATCH0, 2), 8'h0F);
        wr(ad(IDX_CFG2_0, 1), 8'hFF);
        wr(ad(IDX_LATCH0, 1), 8'h00);
        tick(3);
        chk(32'(pinOe[7:0]), 32'hFF);
        chk(32'(pinOut[7:0] & pinOe[7:0]), 32'hA5);
        chk(32'(pinOe[23:16]), 32'hF0);
        chk(32'(pinWeakPullup[23:16]), 32'h0F);
        chk(32'(pinOe[15:8]), 32'hDF);
        chk(32'(pinOut[15:8] & pinOe[15:8]), 32'h0);
        chk(32'(pinWeakPullup[15:8]), 32'h0);
        @(posedge clk);
        extEn[16] <= 1'b1;
        tick(12);
        rd(ad(IDX_PINS0, 2));
        chk(rdat, 32'h0E);
        wr(ad(IDX_CFG1_0, 1), 8'h00);
        wr(ad(IDX_LATCH0, 1), 8'hFF);
        tick(3);
        chk(32'(pinOe[15:8]), 32'hD3);
        $display("t_drive done");
    endtask
    task automatic t_status;
        for (int c = 0; c < 3; c++) begin
            for (int r = 0; r < 2; r++) begin
                wr(ad(IDX_OPTION, 0), 8'(r * 4 + c));
                chk(32'(resp), 32'(RESP_OKAY));
                rd(ad(IDX_STATUS, 0));
                chk(rdat, 32'(26 - r - (c != 0) - (c == 2)));
            end
        end
        rd(8'hFC);
        chk(32'(resp), 32'(RESP_SLVERR));
        wr(ad(IDX_STATUS, 0), 8'h00);
        chk(32'(resp), 32'(RESP_SLVERR));
        $display("t_status done");
    endtask
    task automatic t_analog;
        wr(ad(IDX_CFG1_0, 0), 8'hFF);
        wr(ad(IDX_CFG2_0, 0), 8'h00);
        wr(ad(IDX_ADIS, 0), 8'hFF);
        rd(ad(IDX_ADIS, 0));
        chk(rdat, 32'h3E);
        @(posedge clk);
        extEn[7:0] <= 8'hFF;
        extLevel[7:0] <= 8'hFF;
        tick(12);
        chk(32'(pinDigital[7:0]), 32'hC1);
        @(posedge clk);
        extLevel[0] <= 1'b0;
        repeat (2) @(posedge clk);
        extLevel[0] <= 1'b1;
        repeat (12) begin
            tick(1);
            chk(32'(pinDigital[0]), 32'h1);
        end
        @(posedge clk);
        extLevel[0] <= 1'b0;
        tick(3);
        chk(32'(pinDigital[0]), 32'h1);
        tick(10);
        chk(32'(pinDigital[0]), 32'h0);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        tick(2);
        chk(32'(pinOe), 32'h0);
        rd(ad(IDX_ADIS, 0));
        chk(rdat, 32'h0);
        $display("t_analog done");
    endtask
    // --------
    // Run
    // --------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, extLevel, extEn} = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        tick(2);
        t_reset();
        t_drive();
        t_status();
        t_analog();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end
endmodule

// >>> tb/pin_world.sv
module pin_world (
    // Clock
    input  wire logic                           clk,
    // Device drive
    input  wire logic [gpio_cfg_pkg::NUM_PINS-1:0] pinOut,
    input  wire logic [gpio_cfg_pkg::NUM_PINS-1:0] pinOe,
    input  wire logic [gpio_cfg_pkg::NUM_PINS-1:0] pinWeakPullup,
    // Outside drive
    input  wire logic [gpio_cfg_pkg::NUM_PINS-1:0] extLevel,
    input  wire logic [gpio_cfg_pkg::NUM_PINS-1:0] extEn,
    // Wire level
    output logic [gpio_cfg_pkg::NUM_PINS-1:0]      pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_cfg_pkg::*;
    logic [NUM_PINS-1:0] floatLvl = '0;
    // --------
    // Wire level
    // --------
    always @(posedge clk) floatLvl <= ~floatLvl;
    assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extLevel)
        | (~pinOe & ~extEn & (pinWeakPullup | floatLvl));
endmodule
